// ---- hw/asq_pkg.sv ----
package asq_pkg;

   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LIST_LEN = 8'h04;
   localparam logic [ADDR_W-1:0] REG_LIST_PTR = 8'h08;
   localparam logic [ADDR_W-1:0] REG_LIST_DATA = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_DELAY_LO = 8'h10;
   localparam logic [ADDR_W-1:0] REG_DELAY_HI = 8'h14;
   localparam logic [ADDR_W-1:0] REG_OVERSMP = 8'h18;
   localparam logic [ADDR_W-1:0] REG_DIG_EN = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_CNT_CFG = 8'h20;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] REG_DIG_NOW = 8'h28;
   localparam logic [ADDR_W-1:0] REG_CNT_NOW0 = 8'h30;
   localparam logic [ADDR_W-1:0] REG_CNT_NOW3 = 8'h3C;

   // Control fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_DLY_EN = 1;
   localparam int CTRL_AZ_EN = 2;
   localparam int CTRL_DMODE_LSB = 3;
   localparam int DMODE_W = 2;
   localparam logic [DMODE_W-1:0] DMODE_ASYNC = 2'h0;
   localparam logic [DMODE_W-1:0] DMODE_ONCE = 2'h1;
   localparam logic [DMODE_W-1:0] DMODE_EVERY = 2'h2;

   // Channel list entry layout
   localparam int CHAN_W = 6;
   localparam int RANGE_W = 3;
   localparam int ENT_RANGE_LSB = 6;
   localparam int ENT_DIFF_BIT = 9;
   localparam int ENT_TEMP_BIT = 10;
   localparam int ENT_W = 11;
   localparam int LIST_DEPTH = 512;
   localparam int LIST_AW = 9;
   localparam int LEN_W = 10;
   localparam logic [RANGE_W-1:0] RANGE_MAX = 3'h6;

   // Terminal blocks of four channels
   localparam int BLK_W = 4;
   localparam int NUM_BLK = 16;

   // Data widths
   localparam int DIG_W = 24;
   localparam int CNT_N = 4;
   localparam int CNT_W = 32;
   localparam int CMODE_W = 2;
   localparam int SMP_W = 16;
   localparam int OS_W = 8;
   localparam int ACC_W = 24;
   localparam int EMIT_N = 2 + 2 * CNT_N;
   localparam int EMIT_W = 4;
   localparam int CFG_MODE_LSB = 4;

   // Timing
   localparam int CLK_PS = 20000;
   localparam int SLOT_PS = 1000000;
   localparam int SLOT_CYC = (SLOT_PS + CLK_PS - 1) / CLK_PS;
   localparam int SLOT_W = 6;
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYC - 1);
   localparam int STEP_PS = 20833;
   localparam int STEP_ACC_W = 16;
   localparam int DLY_W = 42;
   localparam int DLY_HI_W = DLY_W - DATA_W;

   typedef enum logic [1:0] {ASQ_K_ANALOG, ASQ_K_DIGITAL,
                             ASQ_K_COUNTER} asq_kind_e;
   typedef enum logic [1:0] {ASQ_C_LIST, ASQ_C_COLDJ,
                             ASQ_C_AUTOZERO} asq_conv_e;

endpackage : asq_pkg

// ---- hw/asq_avg_div.sv ----
`timescale 1ns/10ps
`default_nettype none
module asq_avg_div (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request
   input wire logic start_i,
   input wire logic [asq_pkg::ACC_W-1:0] sum_i,
   input wire logic [asq_pkg::OS_W:0] count_i,
   // Answer
   output logic done_o,
   output logic [asq_pkg::SMP_W-1:0] avg_o
);
   import asq_pkg::*;

   logic [ACC_W-1:0] quo_reg;
   logic [OS_W+1:0] rem_reg;
   logic [OS_W:0] div_reg;
   logic [4:0] bit_reg;
   logic busy_reg;
   logic [OS_W+1:0] trial;

   // Shift in next dividend bit
   assign trial = {rem_reg[OS_W:0], quo_reg[ACC_W-1]};

   // Restoring division, one bit a cycle, fits well inside a slot
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         quo_reg <= '0;
         rem_reg <= '0;
         div_reg <= '0;
         bit_reg <= '0;
         busy_reg <= 1'b0;
         done_o <= 1'b0;
         avg_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            quo_reg <= sum_i;
            rem_reg <= '0;
            div_reg <= count_i;
            bit_reg <= 5'(ACC_W - 1);
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (trial >= {1'b0, div_reg}) begin
               rem_reg <= trial - {1'b0, div_reg};
               quo_reg <= {quo_reg[ACC_W-2:0], 1'b1};
            end else begin
               rem_reg <= trial;
               quo_reg <= {quo_reg[ACC_W-2:0], 1'b0};
            end
            if (bit_reg == 5'h00) begin
               busy_reg <= 1'b0;
               done_o <= 1'b1;
               // Average of 16-bit samples never exceeds 16 bits
               avg_o <= (trial >= {1'b0, div_reg}) ?
                        {quo_reg[SMP_W-2:0], 1'b1} :
                        {quo_reg[SMP_W-2:0], 1'b0};
            end else begin
               bit_reg <= bit_reg - 5'h01;
            end
         end
      end
   end

endmodule : asq_avg_div
`default_nettype wire

// ---- hw/asq_scan_seq.sv ----
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module asq_scan_seq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [asq_pkg::ADDR_W-1:0] addr_i,
   input wire logic [asq_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [asq_pkg::DATA_W-1:0] rdata_o,
   // Converter control
   output logic adc_start_o,
   output logic [asq_pkg::CHAN_W-1:0] adc_chan_o,
   output logic [asq_pkg::RANGE_W-1:0] adc_range_o,
   output logic adc_diff_o,
   output asq_pkg::asq_conv_e adc_conv_o,
   input wire logic adc_done_i,
   input wire logic [asq_pkg::SMP_W-1:0] adc_data_i,
   // Digital pins and counter logic
   input wire logic [asq_pkg::DIG_W-1:0] dig_i,
   input wire logic [asq_pkg::CNT_N*asq_pkg::CNT_W-1:0] cnt_value_i,
   output logic [asq_pkg::CNT_N*asq_pkg::CMODE_W-1:0] cnt_mode_o,
   // Sample stream toward DMA
   output logic out_valid_o,
   output logic [asq_pkg::SMP_W-1:0] out_data_o,
   output asq_pkg::asq_kind_e out_kind_o,
   output logic scan_start_o
);
   import asq_pkg::*;

   typedef enum logic [1:0] {ASQ_IDLE, ASQ_CONV, ASQ_WAIT} asq_state_e;

   ////////////////////////////////////////////////////////////////////////
   // Registers and storage

   logic [ENT_W-1:0] list_mem [LIST_DEPTH];
   logic [DATA_W-1:0] ctrl_reg;
   logic [LEN_W-1:0] len_reg;
   logic [LIST_AW-1:0] ptr_reg;
   logic [DLY_W-1:0] delay_reg;
   logic [OS_W-1:0] os_reg;
   logic [DIG_W-1:0] dig_en_reg;
   logic [CNT_N-1:0] cnt_en_reg;
   logic [NUM_BLK-1:0] cj_mask_reg;
   logic [DIG_W-1:0] dig_meta_reg;
   logic [DIG_W-1:0] dig_sync_reg;

   asq_state_e state_reg;
   asq_conv_e phase_reg;
   logic [SLOT_W-1:0] slot_reg;
   logic [OS_W-1:0] os_cnt_reg;
   logic [LIST_AW-1:0] idx_reg;
   logic [BLK_W-1:0] blk_reg;
   logic first_reg;
   logic [DLY_W-1:0] dly_cnt_reg;
   logic [STEP_ACC_W-1:0] step_acc_reg;
   logic [SMP_W-1:0] scans_reg;
   logic [ACC_W-1:0] acc_reg;

   logic [DIG_W-1:0] dig_cap_reg;
   logic [CNT_N*CNT_W-1:0] cnt_cap_reg;
   logic [EMIT_N-1:0] emit_mask_reg;
   logic [EMIT_W-1:0] emit_idx_reg;

   logic running;
   logic [DMODE_W-1:0] dmode;
   logic slot_end;
   logic entry_end;
   logic scan_over;
   logic step_tick;
   logic list_ok;
   logic div_done;
   logic [SMP_W-1:0] div_avg;
   logic [BLK_W:0] cj_next;
   logic [ACC_W-1:0] acc_sum;
   logic [EMIT_N-1:0] emit_sel;

   assign running = ctrl_reg[CTRL_RUN];
   assign dmode = ctrl_reg[CTRL_DMODE_LSB +: DMODE_W];
   assign list_ok = (len_reg != '0);
   assign slot_end = (state_reg == ASQ_CONV) && (slot_reg == SLOT_LAST);
   assign entry_end = slot_end && (os_cnt_reg == os_reg);
   assign acc_sum = acc_reg + ACC_W'(adc_data_i);

   // Next cold-junction block after the current one
   function automatic logic [BLK_W:0] find_blk(
      input logic [NUM_BLK-1:0] mask, input logic [BLK_W:0] from);
      logic [BLK_W:0] hit;
      // Top bit set means no further block needs a reference
      hit = (BLK_W+1)'(NUM_BLK);
      for (int i = NUM_BLK - 1; i >= 0; i--) begin
         if (mask[i] && (i >= int'(from))) begin
            hit = (BLK_W+1)'(i);
         end
      end
      return hit;
   endfunction : find_blk

   // Scan ends after list, cold-junction and autozero entries
   always_comb begin
      cj_next = '0;
      scan_over = 1'b0;
      case (phase_reg)
         ASQ_C_LIST: cj_next = find_blk(cj_mask_reg, '0);
         ASQ_C_COLDJ: cj_next = find_blk(cj_mask_reg,
                                         {1'b0, blk_reg} + 5'h01);
         default: cj_next = (BLK_W+1)'(NUM_BLK);
      endcase
      case (phase_reg)
         ASQ_C_LIST: scan_over = (idx_reg == LIST_AW'(len_reg - 1'b1))
                                 && cj_next[BLK_W]
                                 && !ctrl_reg[CTRL_AZ_EN];
         ASQ_C_COLDJ: scan_over = cj_next[BLK_W] && !ctrl_reg[CTRL_AZ_EN];
         ASQ_C_AUTOZERO: scan_over = 1'b1;
         default: scan_over = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   // Software configuration
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= '0;
         len_reg <= '0;
         delay_reg <= '0;
         os_reg <= '0;
         dig_en_reg <= '0;
         cnt_en_reg <= '0;
         cnt_mode_o <= '0;
      end else if (wr_i) begin
         case (addr_i)
            REG_CTRL: ctrl_reg <= wdata_i;
            REG_LIST_LEN: if (!running) begin
               len_reg <= (wdata_i[LEN_W-1:0] > LEN_W'(LIST_DEPTH)) ?
                          LEN_W'(LIST_DEPTH) : wdata_i[LEN_W-1:0];
            end
            REG_DELAY_LO: delay_reg[DATA_W-1:0] <= wdata_i;
            REG_DELAY_HI: delay_reg[DLY_W-1:DATA_W] <= wdata_i[DLY_HI_W-1:0];
            REG_OVERSMP: os_reg <= wdata_i[OS_W-1:0];
            REG_DIG_EN: dig_en_reg <= wdata_i[DIG_W-1:0];
            REG_CNT_CFG: begin
               cnt_en_reg <= wdata_i[CNT_N-1:0];
               cnt_mode_o <= wdata_i[CFG_MODE_LSB +: CNT_N*CMODE_W];
            end
            default: ;
         endcase
      end
   end

   // List loading, refused while a scan runs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_reg <= '0;
         cj_mask_reg <= '0;
      end else if (wr_i && !running) begin
         if (addr_i == REG_LIST_PTR) begin
            ptr_reg <= wdata_i[LIST_AW-1:0];
            if (wdata_i[LIST_AW-1:0] == '0) begin
               cj_mask_reg <= '0;
            end
         end else if (addr_i == REG_LIST_DATA) begin
            ptr_reg <= ptr_reg + 1'b1;
            if (wdata_i[ENT_TEMP_BIT]) begin
               cj_mask_reg[wdata_i[CHAN_W-1:CHAN_W-BLK_W]] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_i && !running && (addr_i == REG_LIST_DATA)) begin
         list_mem[ptr_reg] <= wdata_i[ENT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= '0;
         case (addr_i)
            REG_CTRL: rdata_o <= ctrl_reg;
            REG_LIST_LEN: rdata_o <= DATA_W'(len_reg);
            REG_LIST_PTR: rdata_o <= DATA_W'(ptr_reg);
            REG_DELAY_LO: rdata_o <= delay_reg[DATA_W-1:0];
            REG_DELAY_HI: rdata_o <= DATA_W'(delay_reg[DLY_W-1:DATA_W]);
            REG_OVERSMP: rdata_o <= DATA_W'(os_reg);
            REG_DIG_EN: rdata_o <= DATA_W'(dig_en_reg);
            REG_CNT_CFG: rdata_o <= DATA_W'({cnt_mode_o, cnt_en_reg});
            REG_STATUS: rdata_o <= DATA_W'({scans_reg, cj_mask_reg,
               (state_reg == ASQ_WAIT), (state_reg == ASQ_CONV)});
            REG_DIG_NOW: rdata_o <= DATA_W'(dig_sync_reg);
            default: begin
               if (addr_i >= REG_CNT_NOW0 && addr_i <= REG_CNT_NOW3) begin
                  rdata_o <= cnt_value_i[addr_i[3:2]*CNT_W +: CNT_W];
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Pin synchroniser for digital inputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dig_meta_reg <= '0;
         dig_sync_reg <= '0;
      end else begin
         dig_meta_reg <= dig_i;
         dig_sync_reg <= dig_meta_reg;
      end
   end

   // Fractional step enable, averages one tick per 20.83 ns
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_acc_reg <= '0;
      end else if (step_tick) begin
         step_acc_reg <= step_acc_reg + STEP_ACC_W'(CLK_PS - STEP_PS);
      end else begin
         step_acc_reg <= step_acc_reg + STEP_ACC_W'(CLK_PS);
      end
   end
   assign step_tick = (step_acc_reg >= STEP_ACC_W'(STEP_PS));

   // Slot, entry and scan stepping
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ASQ_IDLE;
         phase_reg <= ASQ_C_LIST;
         slot_reg <= '0;
         os_cnt_reg <= '0;
         idx_reg <= '0;
         blk_reg <= '0;
         first_reg <= 1'b0;
         dly_cnt_reg <= '0;
         scans_reg <= '0;
      end else if (!running || !list_ok) begin
         state_reg <= ASQ_IDLE;
      end else begin
         case (state_reg)
            ASQ_IDLE: begin
               state_reg <= ASQ_CONV;
               phase_reg <= ASQ_C_LIST;
               slot_reg <= '0;
               os_cnt_reg <= '0;
               idx_reg <= '0;
               first_reg <= 1'b1;
            end
            ASQ_CONV: begin
               slot_reg <= slot_end ? '0 : slot_reg + 1'b1;
               if (slot_end) begin
                  first_reg <= 1'b0;
                  // same count for every analog entry
                  os_cnt_reg <= entry_end ? '0 : os_cnt_reg + 1'b1;
               end
               if (entry_end && scan_over) begin
                  scans_reg <= scans_reg + 1'b1;
                  phase_reg <= ASQ_C_LIST;
                  idx_reg <= '0;
                  first_reg <= 1'b1;
                  // restart at once or after delay
                  if (ctrl_reg[CTRL_DLY_EN] && (delay_reg != '0)) begin
                     state_reg <= ASQ_WAIT;
                     dly_cnt_reg <= delay_reg;
                  end
               end else if (entry_end) begin
                  case (phase_reg)
                     ASQ_C_LIST: begin
                        if (idx_reg != LIST_AW'(len_reg - 1'b1)) begin
                           idx_reg <= idx_reg + 1'b1;
                        end else if (!cj_next[BLK_W]) begin
                           phase_reg <= ASQ_C_COLDJ;
                           blk_reg <= cj_next[BLK_W-1:0];
                        end else begin
                           phase_reg <= ASQ_C_AUTOZERO;
                        end
                     end
                     ASQ_C_COLDJ: begin
                        if (!cj_next[BLK_W]) begin
                           blk_reg <= cj_next[BLK_W-1:0];
                        end else begin
                           phase_reg <= ASQ_C_AUTOZERO;
                        end
                     end
                     default: phase_reg <= ASQ_C_LIST;
                  endcase
               end
            end
            ASQ_WAIT: begin
               if (step_tick) begin
                  dly_cnt_reg <= dly_cnt_reg - 1'b1;
                  if (dly_cnt_reg == DLY_W'(1)) begin
                     state_reg <= ASQ_CONV;
                     slot_reg <= '0;
                  end
               end
            end
            default: state_reg <= ASQ_IDLE;
         endcase
      end
   end

   // entry range and input type reach converter
   always_comb begin
      adc_conv_o = phase_reg;
      adc_chan_o = list_mem[idx_reg][CHAN_W-1:0];
      adc_range_o = list_mem[idx_reg][ENT_RANGE_LSB +: RANGE_W];
      adc_diff_o = list_mem[idx_reg][ENT_DIFF_BIT];
      if (adc_range_o > RANGE_MAX) begin
         adc_range_o = RANGE_MAX;
      end
      if (phase_reg != ASQ_C_LIST) begin
         adc_chan_o = CHAN_W'(blk_reg);
         adc_range_o = '0;
         adc_diff_o = 1'b0;
      end
   end
   assign adc_start_o = (state_reg == ASQ_CONV) && (slot_reg == '0);
   assign scan_start_o = adc_start_o && first_reg && (os_cnt_reg == '0);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_reg <= '0;
      end else if (state_reg != ASQ_CONV) begin
         acc_reg <= '0;
      end else if (adc_done_i) begin
         acc_reg <= acc_sum;
      end else if (entry_end) begin
         acc_reg <= '0;
      end
   end

   asq_avg_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(entry_end),
      .sum_i(acc_reg),
      .count_i({1'b0, os_reg} + 9'h001),
      .done_o(div_done),
      .avg_o(div_avg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Digital and counter capture

   // capture rides on slot start, no slot used
   always_comb begin
      emit_sel = '0;
      // once per scan, first slot only
      if (scan_start_o && (dmode != DMODE_ASYNC)) begin
         emit_sel[0] = |dig_en_reg[SMP_W-1:0];
         emit_sel[1] = |dig_en_reg[DIG_W-1:SMP_W];
         for (int c = 0; c < CNT_N; c++) begin
            emit_sel[2 + 2*c] = cnt_en_reg[c];
            emit_sel[3 + 2*c] = cnt_en_reg[c];
         end
      end
      if (adc_start_o && (dmode == DMODE_EVERY)) begin
         emit_sel[0] = |dig_en_reg[SMP_W-1:0];
         emit_sel[1] = |dig_en_reg[DIG_W-1:SMP_W];
      end
   end

   // counters captured only at scan start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dig_cap_reg <= '0;
         cnt_cap_reg <= '0;
         emit_mask_reg <= '0;
         emit_idx_reg <= '0;
      end else if (emit_sel != '0) begin
         dig_cap_reg <= dig_sync_reg & dig_en_reg;
         if (scan_start_o) begin
            cnt_cap_reg <= cnt_value_i;
         end
         emit_mask_reg <= emit_sel;
         emit_idx_reg <= '0;
      end else if (emit_idx_reg != EMIT_W'(EMIT_N)) begin
         emit_idx_reg <= emit_idx_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output stream

   // captured words leave within ten cycles; an average due in the same cycle wins and that word is lost
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
         out_kind_o <= ASQ_K_ANALOG;
      end else begin
         out_valid_o <= 1'b0;
         if (div_done) begin
            out_valid_o <= 1'b1;
            out_data_o <= div_avg;
            out_kind_o <= ASQ_K_ANALOG;
         end else if ((emit_idx_reg != EMIT_W'(EMIT_N)) &&
                      emit_mask_reg[emit_idx_reg]) begin
            out_valid_o <= 1'b1;
            if (emit_idx_reg < EMIT_W'(2)) begin
               out_kind_o <= ASQ_K_DIGITAL;
               out_data_o <= emit_idx_reg[0] ?
                             SMP_W'(dig_cap_reg[DIG_W-1:SMP_W]) :
                             dig_cap_reg[SMP_W-1:0];
            end else begin
               out_kind_o <= ASQ_K_COUNTER;
               out_data_o <= cnt_cap_reg[(emit_idx_reg - 4'h2)*SMP_W +: SMP_W];
            end
         end
      end
   end

endmodule : asq_scan_seq
`default_nettype wire

// ---- verif/asq_adc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module asq_adc_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Converter handshake
   input wire logic adc_start_i,
   output logic adc_done_o,
   output logic [15:0] adc_data_o
);
   logic odd_reg;
   logic [5:0] wait_reg;
   // Slow and prompt answers alternate; data scrambles when idle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         odd_reg <= 1'b0;
         wait_reg <= 6'h00;
         adc_done_o <= 1'b0;
         adc_data_o <= 16'h0000;
      end else begin
         adc_done_o <= wait_reg == 6'h01;
         adc_data_o <= ~adc_data_o;
         if (wait_reg == 6'h01) adc_data_o <= odd_reg ? 16'h1230 : 16'h1232;
         if (adc_start_i) wait_reg <= odd_reg ? 6'h28 : 6'h01;
         else if (wait_reg != 6'h00) wait_reg <= wait_reg - 6'h01;
         if (adc_start_i) odd_reg <= ~odd_reg;
      end
   end
endmodule : asq_adc_model
`default_nettype wire

// ---- verif/asq_scan_seq_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module asq_scan_seq_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Converter and stream
   input wire logic adc_start_o,
   input wire logic [asq_pkg::RANGE_W-1:0] adc_range_o,
   input wire asq_pkg::asq_conv_e adc_conv_o,
   input wire logic out_valid_o,
   input wire asq_pkg::asq_kind_e out_kind_o,
   input wire logic scan_start_o
);
   import asq_pkg::*;
   logic [6:0] slot_reg;
   logic [6:0] scan_reg;
   logic ana;
   assign ana = out_valid_o && out_kind_o == ASQ_K_ANALOG;
   // Distance from slot and scan start, saturating
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         slot_reg <= 7'h7F;
         scan_reg <= 7'h7F;
      end else begin
         if (adc_start_o) slot_reg <= 7'h01;
         else if (slot_reg != 7'h7F) slot_reg <= slot_reg + 7'h01;
         if (scan_start_o) scan_reg <= 7'h01;
         else if (scan_reg != 7'h7F) scan_reg <= scan_reg + 7'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_quiet; !adc_start_o [*8]; endsequence
   property p_gap; adc_start_o |-> slot_reg >= 7'h32; endproperty
   property p_quiet; adc_start_o |=> s_quiet; endproperty
   property p_rng; adc_start_o |-> adc_range_o <= RANGE_MAX; endproperty
   property p_ins; adc_start_o && adc_conv_o != ASQ_C_LIST
      |-> adc_range_o == 3'h0; endproperty
   property p_dig; out_valid_o && out_kind_o == ASQ_K_DIGITAL
      |-> slot_reg inside {7'h02, 7'h03}; endproperty
   property p_cnt; out_valid_o && out_kind_o == ASQ_K_COUNTER
      |-> scan_reg inside {[7'h04:7'h0B]}; endproperty
   property p_lat; ana |-> $past(adc_start_o, 75); endproperty
   property p_ord; ana |-> !(scan_reg inside {[7'h01:7'h0B]}); endproperty
   a_gap: assert property (p_gap) else $error("slot short");
   a_quiet: assert property (p_quiet) else $error("restart");
   a_rng: assert property (p_rng) else $error("range");
   a_ins: assert property (p_ins) else $error("ins range");
   a_dig: assert property (p_dig) else $error("dig time");
   a_cnt: assert property (p_cnt) else $error("cnt time");
   a_lat: assert property (p_lat) else $error("avg time");
   a_ord: assert property (p_ord) else $error("order");
endmodule : asq_scan_seq_chk
bind asq_scan_seq asq_scan_seq_chk asq_scan_seq_chk_i (.clk_i, .rst_i,
   .adc_start_o, .adc_range_o, .adc_conv_o, .out_valid_o, .out_kind_o,
   .scan_start_o);
`default_nettype wire

// ---- verif/tb_asq_scan_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_asq_scan_seq;
   import asq_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, cnt_mode_o;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic [23:0] dig_i = 24'hA5C3E7;
   logic [127:0] cnt_value_i = 128'h44440004333300032222000211110001;
   logic adc_done_i, adc_start_o, adc_diff_o, out_valid_o, scan_start_o;
   logic [15:0] adc_data_i, out_data_o, cap[$], exp_q[$];
   logic [5:0] adc_chan_o;
   logic [2:0] adc_range_o;
   logic [11:0] ev[$];
   asq_conv_e adc_conv_o;
   asq_kind_e out_kind_o;
   int error_cnt = 0, n_checks = 0, n_slot, n_scan, n_ana, sc = 0, gap;
   bit chk_ana = 1'b0;
   localparam logic [10:0] EX [5] = '{{ASQ_C_LIST, 6'h05, 3'h6},
      {ASQ_C_LIST, 6'h16, 3'h0}, {ASQ_C_LIST, 6'h17, 3'h2},
      {ASQ_C_COLDJ, 6'h05, 3'h0}, {ASQ_C_AUTOZERO, 6'h00, 3'h0}};
   asq_scan_seq asq_scan_seq_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .adc_start_o, .adc_chan_o, .adc_range_o, .adc_diff_o,
      .adc_conv_o, .adc_done_i, .adc_data_i, .dig_i, .cnt_value_i,
      .cnt_mode_o, .out_valid_o, .out_data_o, .out_kind_o, .scan_start_o);
   asq_adc_model asq_adc_model_i (.clk_i, .rst_i, .adc_start_i(adc_start_o),
      .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));
   ////////////////////////////////////////////////////////////////////
   // Free-running 50 MHz clock
   initial forever #10 clk_i = ~clk_i;
   // Log slots and stream words
   always @(posedge clk_i) begin
      if (scan_start_o) n_scan++;
      if (scan_start_o) gap = sc;
      sc = adc_start_o ? 1 : sc + 1;
      if (adc_start_o) n_slot++;
      if (adc_start_o)
         ev.push_back({adc_diff_o, adc_conv_o, adc_chan_o, adc_range_o});
      if (out_valid_o && out_kind_o != ASQ_K_ANALOG) cap.push_back(out_data_o);
      if (out_valid_o && out_kind_o == ASQ_K_ANALOG) n_ana++;
      if (chk_ana && out_valid_o && out_kind_o == ASQ_K_ANALOG)
         `CHK(out_data_o, 16'h1231)
   end
   task summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] m, e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      `CHK(rdata_o & m, e)
   endtask : rd
   // Reload list pointer and common settings
   task cfg(input logic [31:0] len, os, den, ccfg);
      wr(REG_LIST_PTR, 32'h0);
      wr(REG_LIST_LEN, len);
      wr(REG_OVERSMP, os);
      wr(REG_DELAY_LO, 32'h5);
      wr(REG_DELAY_HI, 32'h0);
      wr(REG_DIG_EN, den);
      wr(REG_CNT_CFG, ccfg);
   endtask : cfg
   // Run until the third scan starts, then stop and let division drain
   task run(input logic [31:0] ctrl, input int gl, gh, es, ea);
      int k;
      n_slot = 0;
      n_ana = 0;
      n_scan = 0;
      k = 0;
      cap.delete();
      ev.delete();
      wr(REG_CTRL, ctrl);
      while (n_scan < 3 && k < 3000) begin
         @(posedge clk_i);
         #1 k++;
      end
      if (k >= 3000) begin
         error_cnt++;
         summarize();
      end
      `CHK(n_slot, es)
      `CHK(n_ana, ea)
      `CHK(cap.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(cap[i], exp_q[i])
      `CHK(gap inside {[gl:gh]}, 1'b1)
      @(posedge clk_i);
      wr(REG_CTRL, 32'h0);
      repeat (30) @(posedge clk_i);
      $display("test ctrl %0h done", ctrl);
   endtask : run
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Pin synchroniser needs two edges before live reads are valid
      repeat (2) @(posedge clk_i);
      rd(REG_DIG_NOW, 32'hFFFFFFFF, 32'h00A5C3E7);
      rd(REG_CNT_NOW3, 32'hFFFFFFFF, 32'h44440004);
      rd(8'h40, 32'hFFFFFFFF, 32'h0);
      cfg(32'h3, 32'h1, 32'hFF00F0, 32'h819);
      wr(REG_LIST_DATA, 32'h3C5);
      wr(REG_LIST_DATA, 32'h416);
      wr(REG_LIST_DATA, 32'h497);
      `CHK(cnt_mode_o, 8'h81)
      exp_q = '{16'h00E0, 16'h00A5, 16'h0001, 16'h1111, 16'h0004, 16'h4444};
      exp_q = {exp_q, exp_q};
      chk_ana = 1'b1;
      run(32'hF, 55, 59, 21, 9);
      chk_ana = 1'b0;
      for (int i = 0; i < 10; i++) begin
         `CHK({ev[i][10:9], ev[i][2:0]}, {EX[i/2][10:9], EX[i/2][2:0]})
         if (i < 8) `CHK(ev[i][8:3], EX[i/2][8:3])
         `CHK(ev[i][11], i < 2)
      end
      rd(REG_STATUS, 32'h3FFFF, 32'h80);
      cfg(32'h2, 32'h0, 32'hFFFF, 32'hC2);
      wr(REG_LIST_DATA, 32'h1);
      wr(REG_LIST_DATA, 32'h182);
      `CHK(cnt_mode_o, 8'h0C)
      exp_q = '{16'hC3E7, 16'h0002, 16'h2222, 16'hC3E7};
      exp_q = {exp_q, exp_q};
      run(32'h11, 50, 53, 5, 3);
      cfg(32'h1, 32'h0, 32'hFFFF, 32'hC2);
      wr(REG_LIST_DATA, 32'h3);
      exp_q.delete();
      run(32'h1, 50, 53, 3, 1);
      summarize();
   end
endmodule : tb_asq_scan_seq
`default_nettype wire
